// ---- design/opdec_regs.vh ----
/*
 Constants for the opcode and operand decoder: opcode values, operation
 codes, field positions and pair/operation encodings.
 Assumes inclusion by bare name from the decoder module.
*/
`ifndef OPDEC_REGS_VH
`define OPDEC_REGS_VH

// Single-byte opcodes handled by this block
`define OPC_MOV_SADDR_IMM   8'h3a
`define OPC_MOV_SFR_IMM     8'h2b
`define OPC_MOV_A_SADDR     8'h20
`define OPC_MOV_SADDR_A     8'h22
`define OPC_XCH_A_SADDR     8'h21
`define OPC_MOV_A_SFR       8'h10
`define OPC_MOV_SFR_A       8'h12
`define OPC_WORD_MOVE_AX_SFRP    8'h11
`define OPC_WORD_MOVE_SFRP_AX    8'h13
`define OPC_INC_SADDR       8'h26
`define OPC_DEC_SADDR       8'h27
`define OPC_WORD_MOVE_SADDRP_IMM 8'h0c
`define OPC_WORD_MOVE_AX_SADDRP  8'h1c
`define OPC_WORD_MOVE_SADDRP_AX  8'h1a
`define OPC_WORD_SUBTRACT_AX_SADDRP  8'h1e
`define OPC_WORD_COMPARE_AX_SADDRP  8'h1f
`define OPC_REG_REG         8'h24

// Upper nibbles of the arithmetic groups; low nibble 1xxx is the operation
`define HI_ALU_A_IMM        4'ha
`define HI_ALU_A_SADDR      4'h9
`define HI_ALU_SADDR_IMM    4'h6

// Decoded operation codes presented to the datapath
`define OP_NONE             5'h00
`define OP_ALU_A_IMM        5'h01
`define OP_ALU_A_SADDR      5'h02
`define OP_ALU_SADDR_IMM    5'h03
`define OP_MOV_SADDR_IMM    5'h04
`define OP_MOV_SFR_IMM      5'h05
`define OP_MOV_A_SADDR      5'h06
`define OP_MOV_SADDR_A      5'h07
`define OP_XCH_A_SADDR      5'h08
`define OP_MOV_A_SFR        5'h09
`define OP_MOV_SFR_A        5'h0a
`define OP_WORD_MOVE_AX_SFRP     5'h0b
`define OP_WORD_MOVE_SFRP_AX     5'h0c
`define OP_INC_SADDR        5'h0d
`define OP_DEC_SADDR        5'h0e
`define OP_WORD_MOVE_SADDRP_IMM  5'h0f
`define OP_WORD_MOVE_AX_SADDRP   5'h10
`define OP_WORD_MOVE_SADDRP_AX   5'h11
`define OP_WORD_SUBTRACT_AX_SADDRP   5'h12
`define OP_WORD_COMPARE_AX_SADDRP   5'h13
`define OP_REG_REG          5'h14
`define OP_UNKNOWN          5'h1f

// Arithmetic operation selector (opcode low three bits with bit 3 set)
`define ALU_ADD             3'h0
`define ALU_ADD_WITH_CARRY            3'h1
`define ALU_SUB             3'h2
`define ALU_SUBTRACT_WITH_BORROW            3'h3
`define ALU_AND             3'h4
`define ALU_XOR             3'h5
`define ALU_OR              3'h6
`define ALU_CMP             3'h7

// Address pages for short-direct and special registers (high bytes)
`define SADDR_PAGE          8'hfe
`define SFR_PAGE            8'hff

// Register pair encodings
`define RP_ACC              2'h0
`define RP_SECOND           2'h1
`define RP_THIRD            2'h2
`define RP_FOURTH           2'h3

// Field positions
`define BITNUM_MSB          2
`define SHCNT_MSB           6
`define SHCNT_LSB           4
`define SCALL_HI_MSB        2
`define TCALL_MSB           4

`endif

// ---- design/opcode_operand_decoder.v ----
/*
 Opcode and operand decoder: takes the instruction byte stream from fetch,
 collects operand bytes and presents one decoded instruction to the
 execution datapath.
 Assumes fetch offers one byte per cycle with i_byte_valid and that the
 datapath accepts a decoded instruction with i_exec_ready.
*/
// Operation
// - Register-to-register: upper nibble is first operand, lower nibble second.
// - Byte-immediate forms take one whole byte as the immediate.
// - Word-immediate is two bytes, low byte first, then high byte.
// - Short-direct offset byte is the low byte of the operand address.
// - Special-register offset byte is the low byte of the register address.
// - Indexed word offset: low offset byte first, high byte second.
// - Absolute address: low address byte first, high byte second.
// - Displacement is signed 8-bit, added to the next instruction address.
// - Short call: low 11 target bits come from the call field.
// - Table call index: five bits equal to table address divided by two.
// - Bit number field is bit position; count field is shift count.
// - Opcode 3a, offset, data: store immediate to short-direct.
// - Opcode 2b, offset, data: write immediate to special register.
// - Low opcode bits select add, add_with_carry, sub, subtract_with_borrow, and, xor, or, compare.
// - Opcode 68 group, offset, data: short-direct with immediate arithmetic.
// - Opcodes 26/27 with offset: increment/decrement short-direct byte.
// - Opcode 0c, offset, low, high: word immediate store to short-direct.
// - Opcodes 1c/1a with offset: word move into/from accumulator pair.
// - Opcodes 1e/1f with offset: word subtract/compare with accumulator pair.
// - Opcodes 20/22/21 with offset: load, store, exchange accumulator.
// - Opcodes 10/12 with offset: special-register byte read/write.
// - Opcodes 11/13 with offset: special-register pair read/write.
`timescale 1ns/100ps
`include "opdec_regs.vh"

module opcode_operand_decoder (
   input  wire        i_sys_clk,      // System clock, 25 MHz
   input  wire        i_nrst,         // Asynchronous reset, active low
   input  wire [7:0]  i_byte,         // Instruction byte from fetch
   input  wire        i_byte_valid,   // Fetch offers i_byte
   output wire        o_byte_ready,   // Decoder takes i_byte this cycle
   input  wire [15:0] i_byte_addr,    // Address of the offered byte
   input  wire        i_exec_ready,   // Datapath accepts the decoded result
   output reg         o_dec_valid,    // Decoded instruction is presented
   output reg  [4:0]  o_op,           // Decoded operation code
   output reg  [2:0]  o_alu_sel,      // Arithmetic operation selector
   output reg  [7:0]  o_imm8,         // Byte immediate
   output reg  [15:0] o_imm16,        // Word immediate
   output reg  [15:0] o_mem_addr,     // Short-direct or special-register address
   output reg  [3:0]  o_first_spec,   // First operand specifier
   output reg  [3:0]  o_second_spec,  // Second operand specifier
   output reg  [1:0]  o_pair_sel,     // Register pair selector of second spec
   output reg  [15:0] o_branch_target,// Next address plus signed displacement
   output reg  [10:0] o_short_call_target, // Low 11 bits of short-call target
   output reg  [4:0]  o_call_table_address,// Table-call index field
   output reg  [2:0]  o_bit_number_field,  // Bit position of bit operand
   output reg  [2:0]  o_shift_count_field, // Shift or rotate count
   output reg  [15:0] o_abs_addr      // Absolute address from two bytes
);

   // ************************************************************
   // Collection state
   // ************************************************************
   localparam ST_OPC  = 2'h0;
   localparam ST_OPND = 2'h1;
   localparam ST_OUT  = 2'h2;

   reg  [1:0]  state;
   reg  [7:0]  opc;
   reg  [7:0]  b2;
   reg  [7:0]  b3;
   reg  [1:0]  got;
   reg  [15:0] opc_addr;
   reg  [1:0]  need;
   reg  [1:0]  next_state;

   // ************************************************************
   // Operand byte count
   // ************************************************************
   // Unlisted codes count as zero operand bytes, so a foreign opcode never hangs the stream
   function [1:0] opnd_count;
      input [7:0] op;
      begin
         opnd_count = 2'd0;
         case (op)
            `OPC_MOV_SADDR_IMM,
            `OPC_MOV_SFR_IMM: opnd_count = 2'd2;
            `OPC_WORD_MOVE_SADDRP_IMM: opnd_count = 2'd3;
            `OPC_MOV_A_SADDR,
            `OPC_MOV_SADDR_A,
            `OPC_XCH_A_SADDR,
            `OPC_MOV_A_SFR,
            `OPC_MOV_SFR_A,
            `OPC_WORD_MOVE_AX_SFRP,
            `OPC_WORD_MOVE_SFRP_AX,
            `OPC_INC_SADDR,
            `OPC_DEC_SADDR,
            `OPC_WORD_MOVE_AX_SADDRP,
            `OPC_WORD_MOVE_SADDRP_AX,
            `OPC_WORD_SUBTRACT_AX_SADDRP,
            `OPC_WORD_COMPARE_AX_SADDRP,
            `OPC_REG_REG: opnd_count = 2'd1;

            default: begin
               if (op[3] && op[7:4] == `HI_ALU_A_IMM) begin
                  opnd_count = 2'd1;
               end else if (op[3] && op[7:4] == `HI_ALU_A_SADDR) begin
                  opnd_count = 2'd1;
               end else if (op[3] && op[7:4] == `HI_ALU_SADDR_IMM) begin
                  opnd_count = 2'd2;
               end
            end
         endcase
      end
   endfunction

   // The opcode byte itself is not yet in opc when it arrives
   wire        take = i_byte_valid && o_byte_ready;
   wire [1:0]  cnt_new = opnd_count(i_byte);

   // A finished instruction blocks the stream until the datapath takes it.
   // Costs one idle cycle per instruction but needs no skid buffer.
   assign o_byte_ready = (state != ST_OUT);

   always @* begin
      next_state = state;

      case (state)
         ST_OPC: begin
            if (take) begin
               next_state = (cnt_new == 2'd0) ? ST_OUT : ST_OPND;
            end
         end
         ST_OPND: begin
            // got counts the operand bytes already taken
            if (take && got + 2'd1 == need) begin
               next_state = ST_OUT;
            end
         end
         ST_OUT: begin
            if (i_exec_ready) begin
               next_state = ST_OPC;
            end
         end
         default: next_state = ST_OPC;
      endcase
   end

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state    <= ST_OPC;
         opc      <= 8'h00;
         b2       <= 8'h00;
         b3       <= 8'h00;
         got      <= 2'd0;
         need     <= 2'd0;
         opc_addr <= 16'h0000;

      end else begin
         state <= next_state;

         if (take && state == ST_OPC) begin
            opc      <= i_byte;
            opc_addr <= i_byte_addr;
            need     <= cnt_new;
            got      <= 2'd0;
         end else if (take && state == ST_OPND) begin
            // Operand bytes shift in strictly in stream order
            if (got == 2'd0) begin
               b2 <= i_byte;
            end else if (got == 2'd1) begin
               b3 <= i_byte;
            end
            got <= got + 2'd1;
         end
      end
   end

   // ************************************************************
   // Field decode of the collected instruction
   // ************************************************************
   // The last byte arrives on i_byte while b2/b3 hold the earlier ones
   reg  [7:0] last;
   reg  [7:0] lo2;
   reg  [7:0] hi2;
   always @* begin
      // Only meaningful in the cycle the final byte is taken
      last = i_byte;
      lo2  = (need == 2'd3) ? b3 : b2;
      hi2  = i_byte;
   end

   reg  [4:0]  next_op;
   reg  [2:0]  next_alu;
   reg  [7:0]  next_imm8;
   reg  [15:0] next_imm16;
   reg  [15:0] next_addr;
   always @* begin
      next_op    = `OP_UNKNOWN;
      next_alu   = opc[2:0];
      next_imm8  = 8'h00;
      next_imm16 = 16'h0000;
      next_addr  = 16'h0000;

      case (opc)
         `OPC_MOV_SADDR_IMM: begin
            next_op   = `OP_MOV_SADDR_IMM;
            next_addr = {`SADDR_PAGE, b2};
            next_imm8 = last;
         end
         `OPC_MOV_SFR_IMM: begin
            next_op   = `OP_MOV_SFR_IMM;
            next_addr = {`SFR_PAGE, b2};
            next_imm8 = last;
         end
         `OPC_WORD_MOVE_SADDRP_IMM: begin
            next_op    = `OP_WORD_MOVE_SADDRP_IMM;
            next_addr  = {`SADDR_PAGE, b2};
            next_imm16 = {hi2, b3};
         end

         `OPC_MOV_A_SADDR,
         `OPC_MOV_SADDR_A,
         `OPC_XCH_A_SADDR,
         `OPC_INC_SADDR,
         `OPC_DEC_SADDR,
         `OPC_WORD_MOVE_AX_SADDRP,
         `OPC_WORD_MOVE_SADDRP_AX,
         `OPC_WORD_SUBTRACT_AX_SADDRP,
         `OPC_WORD_COMPARE_AX_SADDRP: begin
            next_addr = {`SADDR_PAGE, last};
            case (opc)
               `OPC_MOV_A_SADDR:    next_op = `OP_MOV_A_SADDR;
               `OPC_MOV_SADDR_A:    next_op = `OP_MOV_SADDR_A;
               `OPC_XCH_A_SADDR:    next_op = `OP_XCH_A_SADDR;
               `OPC_INC_SADDR:      next_op = `OP_INC_SADDR;
               `OPC_DEC_SADDR:      next_op = `OP_DEC_SADDR;
               `OPC_WORD_MOVE_AX_SADDRP: next_op = `OP_WORD_MOVE_AX_SADDRP;
               `OPC_WORD_MOVE_SADDRP_AX: next_op = `OP_WORD_MOVE_SADDRP_AX;
               `OPC_WORD_SUBTRACT_AX_SADDRP: next_op = `OP_WORD_SUBTRACT_AX_SADDRP;
               default:             next_op = `OP_WORD_COMPARE_AX_SADDRP;
            endcase
         end

         `OPC_MOV_A_SFR,
         `OPC_MOV_SFR_A,
         `OPC_WORD_MOVE_AX_SFRP,
         `OPC_WORD_MOVE_SFRP_AX: begin
            next_addr = {`SFR_PAGE, last};
            case (opc)
               `OPC_MOV_A_SFR:    next_op = `OP_MOV_A_SFR;
               `OPC_MOV_SFR_A:    next_op = `OP_MOV_SFR_A;
               `OPC_WORD_MOVE_AX_SFRP: next_op = `OP_WORD_MOVE_AX_SFRP;
               default:           next_op = `OP_WORD_MOVE_SFRP_AX;
            endcase
         end

         `OPC_REG_REG: begin
            next_op = `OP_REG_REG;
         end

         default: begin
            // Bit 3 set marks the three arithmetic groups
            if (opc[3] && opc[7:4] == `HI_ALU_A_IMM) begin
               next_op   = `OP_ALU_A_IMM;
               next_imm8 = last;
            end else if (opc[3] && opc[7:4] == `HI_ALU_A_SADDR) begin
               next_op   = `OP_ALU_A_SADDR;
               next_addr = {`SADDR_PAGE, last};
            end else if (opc[3] && opc[7:4] == `HI_ALU_SADDR_IMM) begin
               next_op   = `OP_ALU_SADDR_IMM;
               next_addr = {`SADDR_PAGE, b2};
               next_imm8 = last;
            end
         end
      endcase
   end

   // ************************************************************
   // Presentation registers
   // ************************************************************
   // Result loads on the cycle the final byte (or one-byte opcode) is taken
   wire done_opc  = take && state == ST_OPC && cnt_new == 2'd0;
   wire done_opnd = take && state == ST_OPND && got + 2'd1 == need;

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_dec_valid          <= 1'b0;
         o_op                 <= `OP_NONE;
         o_alu_sel            <= `ALU_ADD;
         o_imm8               <= 8'h00;
         o_imm16              <= 16'h0000;
         o_mem_addr           <= 16'h0000;
         o_first_spec         <= 4'h0;
         o_second_spec        <= 4'h0;
         o_pair_sel           <= `RP_ACC;
         o_branch_target      <= 16'h0000;
         o_short_call_target  <= 11'h000;
         o_call_table_address <= 5'h00;
         o_bit_number_field   <= 3'h0;
         o_shift_count_field  <= 3'h0;
         o_abs_addr           <= 16'h0000;

      end else begin
         if (state == ST_OUT && i_exec_ready) begin
            o_dec_valid <= 1'b0;
         end

         // Release never meets a new result: no byte is taken while presenting
         if (done_opc) begin
            // One-byte opcodes outside this block's groups
            o_dec_valid <= 1'b1;
            o_op        <= `OP_UNKNOWN;
            o_alu_sel   <= i_byte[2:0];
            o_call_table_address <= i_byte[4:0];
         end else if (done_opnd) begin
            o_dec_valid <= 1'b1;
            o_op        <= next_op;
            o_alu_sel   <= next_alu;
            o_imm8      <= next_imm8;
            o_imm16     <= next_imm16;
            o_mem_addr  <= next_addr;

            // Generic views of the opcode and operand bytes for other decoders
            o_first_spec  <= last[7:4];
            o_second_spec <= last[3:0];
            o_pair_sel    <= last[2:1];
            o_bit_number_field  <= last[`BITNUM_MSB:0];
            o_shift_count_field <= last[`SHCNT_MSB:`SHCNT_LSB];
            o_short_call_target <= {opc[`SCALL_HI_MSB:0], last};
            o_call_table_address <= opc[`TCALL_MSB:0];
            o_abs_addr <= {hi2, lo2};

            // Displacement is relative to the byte after this instruction
            o_branch_target <= i_byte_addr + 16'h0001
                               + {{8{last[7]}}, last};
         end
      end
   end

endmodule

// ---- verif/opdec_checker.sv ----
/*
 Port checker for the opcode and operand decoder.
 Assumes one clock domain, reset active low, bound from the bench top.
*/
`timescale 1ns/100ps
`include "opdec_regs.vh"
module opdec_checker (
   input wire        i_sys_clk,           // Clock
   input wire        i_nrst,              // Reset, active low
   input wire [7:0]  i_byte,              // Offered byte
   input wire        i_byte_valid,        // Byte offered
   input wire        o_byte_ready,        // Byte taken
   input wire [15:0] i_byte_addr,         // Byte address
   input wire        i_exec_ready,        // Result accepted
   input wire        o_dec_valid,         // Result presented
   input wire [4:0]  o_op,                // Operation
   input wire [7:0]  o_imm8,              // Byte immediate
   input wire [15:0] o_imm16,             // Word immediate
   input wire [15:0] o_mem_addr,          // Operand address
   input wire [3:0]  o_first_spec,        // First specifier
   input wire [3:0]  o_second_spec,       // Second specifier
   input wire [1:0]  o_pair_sel,          // Pair selector
   input wire [15:0] o_branch_target,     // Branch target
   input wire [10:0] o_short_call_target, // Short call bits
   input wire [2:0]  o_bit_number_field,  // Bit position
   input wire [2:0]  o_shift_count_field  // Shift count
);
   // ***************************************************
   // Last byte taken, so outputs can be tied to it
   // ***************************************************
   reg [7:0]  last_b;
   reg [15:0] last_a;
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         last_b <= 8'h00;
         last_a <= 16'h0000;
      end else if (i_byte_valid && o_byte_ready) begin
         last_b <= i_byte;
         last_a <= i_byte_addr;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   a_refuse_busy: assert property (o_dec_valid |-> !o_byte_ready)
      else $error("byte ready while result presented");
   a_hold_out: assert property (o_dec_valid && !i_exec_ready |=> o_dec_valid &&
      $stable(o_op) && $stable(o_imm16) && $stable(o_mem_addr))
      else $error("result changed before acceptance");
   a_drop_accept: assert property (o_dec_valid && i_exec_ready |=> !o_dec_valid)
      else $error("result kept after acceptance");
   // One-byte opcodes carry no operand byte, so the byte views keep their old value
   a_spec_nibbles: assert property ($rose(o_dec_valid) && o_op != `OP_UNKNOWN |->
      {o_first_spec, o_second_spec} == last_b)
      else $error("specifiers not split by nibble");
   a_field_alias: assert property (o_dec_valid |->
      o_bit_number_field == o_second_spec[2:0]
      && o_shift_count_field == o_first_spec[2:0] && o_pair_sel == o_second_spec[2:1])
      else $error("bit, count or pair field misplaced");
   a_call_low: assert property (o_dec_valid |->
      o_short_call_target[7:0] == {o_first_spec, o_second_spec})
      else $error("short call low byte wrong");
   a_branch_calc: assert property ($rose(o_dec_valid) && o_op != `OP_UNKNOWN |->
      o_branch_target == last_a + 16'h0001 + {{8{last_b[7]}}, last_b})
      else $error("branch target wrong");
   a_sadr_page: assert property (o_dec_valid && (o_op == `OP_ALU_A_SADDR ||
      o_op == `OP_WORD_MOVE_SADDRP_IMM || o_op == `OP_INC_SADDR) |-> o_mem_addr[15:8] == `SADDR_PAGE)
      else $error("short-direct page wrong");
   a_sfr_page: assert property (o_dec_valid && (o_op == `OP_MOV_SFR_IMM ||
      o_op == `OP_MOV_A_SFR || o_op == `OP_WORD_MOVE_SFRP_AX) |-> o_mem_addr[15:8] == `SFR_PAGE)
      else $error("special register page wrong");
   a_imm_last: assert property ($rose(o_dec_valid) && o_op == `OP_WORD_MOVE_SADDRP_IMM |->
      o_imm16[15:8] == last_b)
      else $error("word immediate high byte wrong");
   a_byte_imm: assert property ($rose(o_dec_valid) && o_op == `OP_MOV_SADDR_IMM |->
      o_imm8 == last_b)
      else $error("byte immediate wrong");
   c_word: cover property ($rose(o_dec_valid) && o_op == `OP_WORD_MOVE_SADDRP_IMM);
   c_stall: cover property (o_dec_valid && !i_exec_ready ##1 o_dec_valid);
   c_alu: cover property ($rose(o_dec_valid) && o_op == `OP_ALU_SADDR_IMM);
endmodule

// ---- verif/fetch_dp_model.sv ----
/*
 Fetch unit and datapath stand-in driving the decoder inputs.
 Assumes the bench calls feed, then take once the result is shown.
*/
`timescale 1ns/100ps
module fetch_dp_model (
   input  wire        i_sys_clk,    // System clock
   input  wire        i_rdy,        // Decoder takes byte
   output reg  [7:0]  o_byte,       // Offered byte
   output reg         o_valid,      // Byte offered
   output reg  [15:0] o_addr,       // Byte address
   output reg         o_exec_ready  // Result accepted
);
   initial begin
      o_byte = 8'h00;
      o_valid = 1'b0;
      o_addr = 16'h0000;
      o_exec_ready = 1'b0;
   end
   // ***************************************************
   // Byte stream, one instruction at a time
   // ***************************************************
   task feed(input [31:0] code, input [2:0] n, input [15:0] a);
      integer k;
      integer w;
      begin
         for (k = 0; k < n; k = k + 1) begin
            @(negedge i_sys_clk);
            o_byte = code[8*k +: 8];
            o_addr = a + k[15:0];
            o_valid = 1'b1;
            w = 0;
            while (!i_rdy && w < 20) begin
               @(negedge i_sys_clk);
               w = w + 1;
            end
            @(posedge i_sys_clk);
         end
         @(negedge i_sys_clk);
         // Released lines change, so a stale byte can never be taken twice
         o_valid = 1'b0;
         o_byte = ~o_byte;
         o_addr = ~o_addr;
      end
   endtask
   task take(input integer stall);
      begin
         repeat (stall) @(negedge i_sys_clk);
         o_exec_ready = 1'b1;
         @(negedge i_sys_clk);
         o_exec_ready = 1'b0;
      end
   endtask
endmodule

// ---- verif/opcode_operand_decoder_test.sv ----
/*
 Self-checking bench for the opcode and operand decoder.
 Assumes the fetch/datapath model drives inputs at falling edges.
*/
`timescale 1ns/100ps
`include "opdec_regs.vh"
bind opcode_operand_decoder opdec_checker opdec_checker_inst (.i_sys_clk, .i_nrst, .i_byte,
   .i_byte_valid, .o_byte_ready, .i_byte_addr, .i_exec_ready, .o_dec_valid, .o_op, .o_imm8,
   .o_imm16, .o_mem_addr, .o_first_spec, .o_second_spec, .o_pair_sel, .o_branch_target,
   .o_short_call_target, .o_bit_number_field, .o_shift_count_field);
module opcode_operand_decoder_test;
   reg         i_sys_clk;
   reg         i_nrst;
   wire [7:0]  i_byte, o_imm8;
   wire        i_byte_valid, i_exec_ready, o_byte_ready, o_dec_valid;
   wire [15:0] i_byte_addr, o_imm16, o_mem_addr, o_branch_target, o_abs_addr;
   wire [4:0]  o_op, o_call_table_address;
   wire [3:0]  o_first_spec, o_second_spec;
   wire [2:0]  o_alu_sel, o_bit_number_field, o_shift_count_field;
   wire [1:0]  o_pair_sel;
   wire [10:0] o_short_call_target;
   integer     error_cnt;
   integer     cmp_count;
   opcode_operand_decoder opcode_operand_decoder_inst (.i_sys_clk, .i_nrst, .i_byte,
      .i_byte_valid, .o_byte_ready, .i_byte_addr, .i_exec_ready, .o_dec_valid, .o_op,
      .o_alu_sel, .o_imm8, .o_imm16, .o_mem_addr, .o_first_spec, .o_second_spec, .o_pair_sel,
      .o_branch_target, .o_short_call_target, .o_call_table_address, .o_bit_number_field,
      .o_shift_count_field, .o_abs_addr);
   fetch_dp_model fetch_dp_model_inst (.i_sys_clk(i_sys_clk), .i_rdy(o_byte_ready),
      .o_byte(i_byte), .o_valid(i_byte_valid), .o_addr(i_byte_addr), .o_exec_ready(i_exec_ready));
   // ***************************************************
   // Shared tasks
   // ***************************************************
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task run(input [31:0] code, input [2:0] n, input [15:0] a);
      integer w;
      begin
         fetch_dp_model_inst.feed(code, n, a);
         w = 0;
         while (o_dec_valid !== 1'b1 && w < 20) begin
            @(negedge i_sys_clk);
            w = w + 1;
         end
         chk(o_dec_valid, 1'b1);
         chk(o_byte_ready, 1'b0);
      end
   endtask
   task done(input integer stall);
      begin
         fetch_dp_model_inst.take(stall);
         chk(o_dec_valid, 1'b0);
      end
   endtask
   task one(input [7:0] opc, input [4:0] op, input [7:0] pg);
      begin
         run({16'h0000, 8'h9c, opc}, 3'd2, 16'h0300);
         chk(o_op, op);
         chk(o_mem_addr, {pg, 8'h9c});
         done(0);
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
         if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task t_store;
      begin
         run({8'h00, 8'h77, 8'h41, 8'h3a}, 3'd3, 16'h0100);
         chk(o_op, `OP_MOV_SADDR_IMM);
         chk(o_mem_addr, 16'hfe41);
         chk(o_imm8, 8'h77);
         done(1);
         run({8'h00, 8'h5e, 8'h41, 8'h2b}, 3'd3, 16'h0104);
         chk(o_op, `OP_MOV_SFR_IMM);
         chk(o_mem_addr, 16'hff41);
         chk(o_imm8, 8'h5e);
         done(0);
         $display("test store done");
      end
   endtask
   task t_alu;
      integer g, k;
      reg [7:0] opc;
      begin
         for (g = 0; g < 3; g = g + 1) begin
            for (k = 0; k < 8; k = k + 1) begin
               opc = {(g == 0) ? 4'ha : (g == 1) ? 4'h9 : 4'h6, 1'b1, k[2:0]};
               run({8'h00, 8'hc0, 8'h30 + k[7:0], opc}, (g == 2) ? 3'd3 : 3'd2, 16'h0400);
               chk(o_alu_sel, k);
               chk(o_op, (g == 0) ? `OP_ALU_A_IMM :
                  (g == 1) ? `OP_ALU_A_SADDR : `OP_ALU_SADDR_IMM);
               if (g == 0) chk(o_imm8, 8'h30 + k[7:0]);
               else chk(o_mem_addr, {8'hfe, 8'h30 + k[7:0]});
               if (g == 2) chk(o_imm8, 8'hc0);
               done(k % 2);
            end
         end
         $display("test alu done");
      end
   endtask
   task t_one;
      begin
         one(8'h20, `OP_MOV_A_SADDR, 8'hfe);
         one(8'h22, `OP_MOV_SADDR_A, 8'hfe);
         one(8'h21, `OP_XCH_A_SADDR, 8'hfe);
         one(8'h10, `OP_MOV_A_SFR, 8'hff);
         one(8'h12, `OP_MOV_SFR_A, 8'hff);
         one(8'h11, `OP_WORD_MOVE_AX_SFRP, 8'hff);
         one(8'h13, `OP_WORD_MOVE_SFRP_AX, 8'hff);
         one(8'h26, `OP_INC_SADDR, 8'hfe);
         one(8'h27, `OP_DEC_SADDR, 8'hfe);
         one(8'h1c, `OP_WORD_MOVE_AX_SADDRP, 8'hfe);
         one(8'h1a, `OP_WORD_MOVE_SADDRP_AX, 8'hfe);
         one(8'h1e, `OP_WORD_SUBTRACT_AX_SADDRP, 8'hfe);
         one(8'h1f, `OP_WORD_COMPARE_AX_SADDRP, 8'hfe);
         $display("test one-offset done");
      end
   endtask
   task t_word;
      begin
         run({8'hbe, 8'hef, 8'h12, 8'h0c}, 3'd4, 16'h0200);
         chk(o_op, `OP_WORD_MOVE_SADDRP_IMM);
         chk(o_imm16, 16'hbeef);
         chk(o_mem_addr, 16'hfe12);
         chk(o_abs_addr, 16'hbeef);
         done(3);
         $display("test word done");
      end
   endtask
   task t_pairs;
      integer p;
      begin
         for (p = 0; p < 4; p = p + 1) begin
            run({16'h0000, 4'h5, 1'b0, p[1:0], 1'b0, 8'h24}, 3'd2, 16'h0500);
            chk(o_op, `OP_REG_REG);
            chk(o_first_spec, 4'h5);
            chk(o_second_spec, {1'b0, p[1:0], 1'b0});
            chk(o_pair_sel, p);
            done(0);
         end
         $display("test pairs done");
      end
   endtask
   task t_fields;
      begin
         run({16'h0000, 8'hf0, 8'h26}, 3'd2, 16'h1000);
         chk(o_branch_target, 16'h0ff2);
         chk(o_bit_number_field, 3'h0);
         chk(o_shift_count_field, 3'h7);
         chk(o_short_call_target, 11'h6f0);
         done(0);
         run({24'h000000, 8'he5}, 3'd1, 16'h2000);
         chk(o_op, `OP_UNKNOWN);
         chk(o_call_table_address, 5'h05);
         done(0);
         $display("test fields done");
      end
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      conclude;
   end
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      i_nrst = 1'b0;
      repeat (6) @(negedge i_sys_clk);
      chk(o_byte_ready, 1'b1);
      i_nrst = 1'b1;
      t_store;
      t_alu;
      t_one;
      t_word;
      t_pairs;
      t_fields;
      conclude;
   end
endmodule
